// [dv/dodt_assertions.sv]
// Checker beside the link: latencies, strength window, pin holds
`timescale 1ns/1ps
`default_nettype none
module dodt_assertions (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   odt,
    input wire dodt_pkg::dodt_cmd_type cmd,
    input wire logic                   bc4,
    input wire logic [2:0]             ba,
    input wire logic [12:0]            addr,
    input wire logic                   dll_locked,
    input wire logic                   self_refresh,
    input wire logic                   pd_precharge,
    input wire logic                   dq_drive,
    input wire logic                   rtt_on,
    input wire logic                   rtt_wr_sel,
    input wire logic [2:0]             rtt_nom_code,
    input wire logic [1:0]             rtt_wr_code,
    input wire logic                   sync_mode
);
    logic [12:0] mr0_q, mr1_q, mr2_q;
    logic [2:0]  calm_q;
    logic        wr, dyn, en, fz, good;
    assign wr = cmd == dodt_pkg::CMD_WRITE;
    assign dyn = mr2_q[10] | mr2_q[9];
    assign en = dyn | mr1_q[9] | mr1_q[6] | mr1_q[2];
    assign fz = pd_precharge & ~mr0_q[12] & en & ~self_refresh & ~dq_drive;
    // Latency fixed at 3 only while no mode set or forcing input disturbs it
    assign good = dll_locked & ~pd_precharge & ~self_refresh & ~dq_drive & (cmd != dodt_pkg::CMD_MRS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr0_q <= '0;
            mr1_q <= '0;
            mr2_q <= '0;
            calm_q <= '0;
        end else begin
            if (cmd == dodt_pkg::CMD_MRS && ba == 3'h0) mr0_q <= addr;
            if (cmd == dodt_pkg::CMD_MRS && ba == 3'h1) mr1_q <= addr;
            if (cmd == dodt_pkg::CMD_MRS && ba == 3'h2) mr2_q <= addr;
            calm_q <= !good ? 3'h0 : (calm_q == 3'h7 ? calm_q : calm_q + 3'h1);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr4_s; wr && bc4 && dyn; endsequence
    sequence wr8_s; wr && !bc4 && dyn; endsequence
    sequence drop_s; rtt_wr_sel ##1 !rtt_wr_sel; endsequence
    rtt_latency_a: assert property (calm_q == 3'h7 |-> rtt_on == ($past(odt, 4) && en))
        else $error("termination does not follow pin after latency");
    rtt_disabled_a: assert property ((!en)[*6] |-> !rtt_on)
        else $error("termination on while disabled");
    forced_off_a: assert property (self_refresh || dq_drive |=> !rtt_on)
        else $error("termination on while forced off");
    frozen_pin_a: assert property (fz ##1 fz |-> rtt_on == $past(odt))
        else $error("frozen path not following pin");
    sync_mode_a: assert property ($past(presetn) |-> ##1 sync_mode == $past(dll_locked && !(pd_precharge && !mr0_q[12])))
        else $error("timing mode wrong");
    wr_start_a: assert property (wr && dyn |-> ##4 rtt_wr_sel)
        else $error("write strength late");
    wr_end_four_a: assert property (wr4_s ##1 (!wr)[*7] |-> drop_s)
        else $error("write strength end wrong for chop");
    wr_end_eight_a: assert property (wr8_s ##1 (!wr)[*8] |-> ##1 drop_s)
        else $error("write strength end wrong for full burst");
    wr_persist_a: assert property (rtt_wr_sel && wr && dyn |=> rtt_wr_sel)
        else $error("write strength dropped on restart");
    nominal_idle_a: assert property ((!wr)[*8] |-> ##2 !rtt_wr_sel)
        else $error("write strength without write");
    no_dynamic_a: assert property ((!dyn)[*8] ##1 (!dyn)[*4] |-> !rtt_wr_sel)
        else $error("write strength with dynamic mode off");
    codes_a: assert property ((cmd != dodt_pkg::CMD_MRS)[*3] |->
        rtt_nom_code == {mr1_q[9], mr1_q[6], mr1_q[2]} && rtt_wr_code == mr2_q[10:9])
        else $error("strength code mismatch");
    pin_hold_a: assert property ($rose(odt) || (odt && wr) |-> odt[*4])
        else $error("pin low too early");
    pin_hold_eight_a: assert property (odt && wr && !bc4 |-> odt[*6])
        else $error("pin low too early after full burst");
endmodule : dodt_assertions
`default_nettype wire

// [dv/tb_top.sv]
// Bench: controller and DRAM ends joined, APB driver, scoreboards
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        dll_locked, self_refresh, pd_precharge, dq_drive, rtt_on, rtt_wr_sel, sync_mode;
    logic [2:0]  rtt_nom_code;
    logic [1:0]  rtt_wr_code;
    logic [32:0] rd_q[$];
    logic [19:0] cmd_q[$];
    int          bad_count, check_count, lead, quiet;
    logic [12:0] mr1;
    dodt_link_if link ();
    dodt_ctrl_end u_dodt_ctrl_end (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    dodt_dram_end u_dodt_dram_end (.pclk(pclk), .presetn(presetn), .link(link), .dll_locked(dll_locked),
        .self_refresh(self_refresh), .pd_precharge(pd_precharge), .dq_drive(dq_drive), .rtt_on(rtt_on),
        .rtt_wr_sel(rtt_wr_sel), .rtt_nom_code(rtt_nom_code), .rtt_wr_code(rtt_wr_code), .sync_mode(sync_mode));
    dodt_assertions u_dodt_assertions (.pclk(pclk), .presetn(presetn), .odt(link.odt), .cmd(link.cmd),
        .bc4(link.bc4), .ba(link.ba), .addr(link.addr), .dll_locked(dll_locked), .self_refresh(self_refresh),
        .pd_precharge(pd_precharge), .dq_drive(dq_drive), .rtt_on(rtt_on), .rtt_wr_sel(rtt_wr_sel),
        .rtt_nom_code(rtt_nom_code), .rtt_wr_code(rtt_wr_code), .sync_mode(sync_mode));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Queued command word; gap keeps the controller idle for the next one
    task automatic send(input logic [1:0] op, input logic b4, input logic [2:0] ba, input logic [12:0] a,
                        input logic eodt);
        cmd_q.push_back({eodt, op, b4, ba, a});
        apb(1'b1, dodt_pkg::ADDR_CMD, {3'h0, a, 9'h0, ba, 1'b0, b4, op});
        repeat (2) @(posedge pclk);
    endtask : send
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check({pslverr, prdata}, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
        end
        if (link.cmd !== dodt_pkg::CMD_NOP) begin
            check(33'({link.odt, link.cmd, link.bc4, link.ba, link.addr}),
                  33'(cmd_q.size() > 0 ? cmd_q.pop_front() : 'x));
        end
    end
    initial begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        test_done();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {dll_locked, self_refresh, pd_precharge, dq_drive} = 4'h8;
        presetn = 1'b0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(76));
        lead = 1 + $urandom % 8;
        quiet = 1 + $urandom % 8;
        mr1 = 13'h0004 | 13'($urandom & 32'h0240);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(dodt_pkg::ADDR_CTRL, 33'h0);
        rd(dodt_pkg::ADDR_STAT, 33'h0);
        rd(dodt_pkg::ADDR_CMD, 33'h0);
        rd(dodt_pkg::ADDR_TIME, {20'h0, dodt_pkg::QUIET_RST, 3'h0, dodt_pkg::LEAD_RST});
        rd(8'h10, {1'b1, 32'h0});
        apb(1'b1, dodt_pkg::ADDR_TIME, {19'h0, 5'(quiet), 3'h0, 5'(lead)});
        rd(dodt_pkg::ADDR_TIME, {20'h0, 5'(quiet), 3'h0, 5'(lead)});
        send(2'h3, 1'b0, 3'h0, 13'h0000, 1'b0);
        send(2'h3, 1'b0, 3'h1, mr1, 1'b0);
        apb(1'b1, dodt_pkg::ADDR_CTRL, 32'h1);
        repeat (6) @(posedge pclk);
        // Every write strength code, with a write restarting the window
        for (int c = 0; c < 4; c++) begin
            send(2'h3, 1'b0, 3'h2, 13'(c << 9), 1'b1);
            send(2'h1, 1'b1, 3'h0, 13'($urandom), 1'b1);
            send(2'h1, c[0], 3'h0, 13'($urandom), 1'b1);
            repeat (16) @(posedge pclk);
        end
        send(2'h2, 1'b0, 3'h0, 13'($urandom), 1'b0);
        repeat (lead + 4) @(posedge pclk);
        dq_drive <= 1'b1;
        repeat (4) @(posedge pclk);
        dq_drive <= 1'b0;
        repeat (quiet + 16) @(posedge pclk);
        check(33'(rtt_on), 33'h1);
        dq_drive <= 1'b1;
        repeat (2) @(posedge pclk);
        check(33'(rtt_on), 33'h0);
        dq_drive <= 1'b0;
        repeat (2) @(posedge pclk);
        check(33'(rtt_on), 33'h1);
        self_refresh <= 1'b1;
        repeat (3) @(posedge pclk);
        check(33'(rtt_on), 33'h0);
        self_refresh <= 1'b0;
        pd_precharge <= 1'b1;
        apb(1'b1, dodt_pkg::ADDR_CTRL, 32'h0);
        repeat (6) @(posedge pclk);
        check(33'(rtt_on), 33'h0);
        apb(1'b1, dodt_pkg::ADDR_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        check(33'(rtt_on), 33'h1);
        repeat (4) @(posedge pclk);
        pd_precharge <= 1'b0;
        send(2'h3, 1'b0, 3'h0, 13'h1000, 1'b1);
        pd_precharge <= 1'b1;
        repeat (3) @(posedge pclk);
        check(33'(sync_mode), 33'h1);
        pd_precharge <= 1'b0;
        dll_locked <= 1'b0;
        repeat (3) @(posedge pclk);
        dll_locked <= 1'b1;
        apb(1'b1, dodt_pkg::ADDR_CTRL, 32'h0);
        repeat (8) @(posedge pclk);
        send(2'h3, 1'b0, 3'h2, 13'h0604, 1'b0);
        cmd_q.push_back({1'b0, 2'h3, 1'b0, 3'h2, 13'h0004});
        apb(1'b1, dodt_pkg::ADDR_CTRL, 32'h2);
        repeat (8) @(posedge pclk);
        rd(dodt_pkg::ADDR_STAT, 33'h0);
        check(33'(cmd_q.size()), 33'h0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire

// [logic/dodt_ctrl_end.sv]
// Controller side: APB registers, pin sequencing, command issue
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// What the controller and DRAM ends do together
// (R1) Termination enabled by nonzero strength bits
// (R2) Pin low means off; high on if enabled
// (R3) Never decode commands for on/off
// (R4) Synchronous timing whenever DLL runs locked
// (R5) Controller keeps termination off in DLL-off
// (R6) Turn on/off latency after sampled pin
// (R7) Both latencies equal write latency minus two
// (R8) Controller holds pin high four cycles
// (R9) Controller holds pin after write 4/6
// (R10) Controller lowers pin around reads
// (R11) Re-enable termination when driver releases
// (R12) Dynamic mode on when write bits set
// (R13) Strength codes from mode register bits
// (R14) Nominal strength outside writes
// (R15) Write strength after write latency minus two
// (R16) Nominal back after off latency plus 4/6
// (R17) Controller clears write strength in DLL-off
// (R18) Self-refresh forces termination off
// (R19) Frozen power-down: pin acts without latency
// (R20) New write restarts nominal-return countdown
module dodt_ctrl_end (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    dodt_link_if.ctrl        link
);
    typedef enum logic [1:0] {
        CST_IDLE,
        CST_RD_LEAD,
        CST_RD_QUIET
    } dodt_cst_type;

    typedef struct packed {
        logic                      odt_req;
        logic                      dll_off;
        logic                      auto_mrs;
        logic [4:0]                lead;
        logic [4:0]                quiet;
        logic                      req_valid;
        logic [1:0]                req_op;
        logic                      req_bc4;
        logic [2:0]                req_ba;
        logic [dodt_pkg::MR_W-1:0] req_addr;
        logic [dodt_pkg::MR_W-1:0] mr2;
        dodt_cst_type              st;
        logic [4:0]                timer;
        logic [2:0]                hold;
        logic                      odt;
        dodt_pkg::dodt_cmd_type    cmd;
        logic                      bc4;
        logic [2:0]                ba;
        logic [dodt_pkg::MR_W-1:0] addr;
        logic [31:0]               rdata;
    } dodt_ctrl_state_type;

    dodt_ctrl_state_type s_q;
    dodt_ctrl_state_type s_d;

    logic       hit;
    logic       wr_acc;
    logic       want;
    logic [2:0] wr_hold;

    always_comb begin
        s_d = s_q;
        s_d.cmd = dodt_pkg::CMD_NOP;
        hit = (paddr == dodt_pkg::ADDR_CTRL) || (paddr == dodt_pkg::ADDR_CMD) ||
              (paddr == dodt_pkg::ADDR_STAT) || (paddr == dodt_pkg::ADDR_TIME);
        wr_acc = psel && penable && pwrite && hit;

        // Read data captured in setup so it is a flop at access
        if (psel && !penable) begin
            s_d.rdata = '0;
            unique case (paddr)
                dodt_pkg::ADDR_CTRL: begin
                    s_d.rdata[dodt_pkg::CTRL_ODT_REQ] = s_q.odt_req;
                    s_d.rdata[dodt_pkg::CTRL_DLL_OFF] = s_q.dll_off;
                end
                dodt_pkg::ADDR_STAT: begin
                    s_d.rdata[dodt_pkg::STAT_BUSY] = s_q.req_valid || s_q.auto_mrs || (s_q.st != CST_IDLE);
                    s_d.rdata[dodt_pkg::STAT_ODT] = s_q.odt;
                    s_d.rdata[dodt_pkg::STAT_HOLD] = (s_q.hold != 3'h0);
                end
                dodt_pkg::ADDR_TIME: begin
                    s_d.rdata[dodt_pkg::TIME_LEAD_LO +: 5] = s_q.lead;
                    s_d.rdata[dodt_pkg::TIME_QUIET_LO +: 5] = s_q.quiet;
                end
                default: ;
            endcase
        end

        if (wr_acc) begin
            unique case (paddr)
                dodt_pkg::ADDR_CTRL: begin
                    s_d.odt_req = pwdata[dodt_pkg::CTRL_ODT_REQ];
                    s_d.dll_off = pwdata[dodt_pkg::CTRL_DLL_OFF];
                    // (R17) Entering DLL-off clears write strength
                    if (pwdata[dodt_pkg::CTRL_DLL_OFF] && !s_q.dll_off) begin
                        s_d.auto_mrs = 1'b1;
                    end
                end
                dodt_pkg::ADDR_CMD: begin
                    // A command while one is queued is dropped
                    if (!s_q.req_valid) begin
                        s_d.req_valid = 1'b1;
                        s_d.req_op = pwdata[dodt_pkg::CMD_OP_LO +: 2];
                        s_d.req_bc4 = pwdata[dodt_pkg::CMD_BC4];
                        s_d.req_ba = pwdata[dodt_pkg::CMD_BA_LO +: 3];
                        s_d.req_addr = pwdata[dodt_pkg::CMD_ADDR_LO +: dodt_pkg::MR_W];
                    end
                end
                dodt_pkg::ADDR_TIME: begin
                    s_d.lead = pwdata[dodt_pkg::TIME_LEAD_LO +: 5];
                    s_d.quiet = pwdata[dodt_pkg::TIME_QUIET_LO +: 5];
                end
                default: ;
            endcase
        end

        wr_hold = 3'h0;
        unique case (s_q.st)
            CST_IDLE: begin
                if (s_q.auto_mrs) begin
                    s_d.auto_mrs = 1'b0;
                    s_d.cmd = dodt_pkg::CMD_MRS;
                    s_d.ba = dodt_pkg::MR_SEL_2;
                    s_d.addr = s_q.mr2;
                    s_d.addr[dodt_pkg::MR2_WR_HI:dodt_pkg::MR2_WR_LO] = 2'h0;
                    s_d.mr2 = s_d.addr;
                end else if (s_q.req_valid) begin
                    s_d.req_valid = 1'b0;
                    s_d.bc4 = s_q.req_bc4;
                    s_d.ba = s_q.req_ba;
                    s_d.addr = s_q.req_addr;
                    unique case (s_q.req_op)
                        2'h1: begin
                            s_d.cmd = dodt_pkg::CMD_WRITE;
                            wr_hold = s_q.req_bc4 ? 3'(dodt_pkg::ODTH4 - 6'h01) : 3'(dodt_pkg::ODTH8 - 6'h01);
                        end
                        2'h2: begin
                            s_d.st = CST_RD_LEAD;
                            s_d.timer = s_q.lead;
                        end
                        2'h3: begin
                            s_d.cmd = dodt_pkg::CMD_MRS;
                            if (s_q.req_ba == dodt_pkg::MR_SEL_2) begin
                                s_d.mr2 = s_q.req_addr;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            CST_RD_LEAD: begin
                // (R10) Pin low for lead cycles before the read
                if (!s_q.odt) begin
                    if (s_q.timer == 5'h00) begin
                        s_d.cmd = dodt_pkg::CMD_READ;
                        s_d.st = CST_RD_QUIET;
                        s_d.timer = s_q.quiet;
                    end else begin
                        s_d.timer = s_q.timer - 5'h01;
                    end
                end
            end
            CST_RD_QUIET: begin
                // (R10) Pin stays low past the postamble
                if (s_q.timer == 5'h00) begin
                    s_d.st = CST_IDLE;
                end else begin
                    s_d.timer = s_q.timer - 5'h01;
                end
            end
            default: s_d.st = CST_IDLE;
        endcase

        // (R5) DLL-off keeps the pin low
        want = s_q.odt_req && !s_q.dll_off && (s_d.st == CST_IDLE);
        // (R8) Pin may drop only once hold runs out
        s_d.odt = want || (s_q.odt && (s_q.hold != 3'h0));
        if (s_q.hold != 3'h0) begin
            s_d.hold = s_q.hold - 3'h1;
        end
        if (s_d.odt && !s_q.odt) begin
            s_d.hold = 3'(dodt_pkg::ODTH4 - 6'h01);
        end
        // (R9) Longer hold after a write with pin high
        if (s_d.odt && (wr_hold > s_d.hold)) begin
            s_d.hold = wr_hold;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.lead <= dodt_pkg::LEAD_RST;
            s_q.quiet <= dodt_pkg::QUIET_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = s_q.rdata;
    assign link.odt = s_q.odt;
    assign link.cmd = s_q.cmd;
    assign link.bc4 = s_q.bc4;
    assign link.ba = s_q.ba;
    assign link.addr = s_q.addr;
endmodule : dodt_ctrl_end
`default_nettype wire

// [logic/dodt_dram_end.sv]
// DRAM-side termination control: pin latency, strength select
`timescale 1ns/1ps
`default_nettype none
module dodt_dram_end (
    input  wire logic      pclk,
    input  wire logic      presetn,
    dodt_link_if.dram      link,
    input  wire logic      dll_locked,
    input  wire logic      self_refresh,
    input  wire logic      pd_precharge,
    input  wire logic      dq_drive,
    output logic           rtt_on,
    output logic           rtt_wr_sel,
    output logic [2:0]     rtt_nom_code,
    output logic [1:0]     rtt_wr_code,
    output logic           sync_mode
);
    typedef struct packed {
        logic [dodt_pkg::MR_W-1:0]   mr0;
        logic [dodt_pkg::MR_W-1:0]   mr1;
        logic [dodt_pkg::MR_W-1:0]   mr2;
        logic [dodt_pkg::HIST_W-1:0] hist;
        logic [dodt_pkg::CNT_W-1:0]  wr_cnt;
        logic                        wr_live;
        logic                        wr_bc4;
        logic                        rtt_on;
        logic                        rtt_wr;
        logic                        sync;
    } dodt_dram_state_type;

    dodt_dram_state_type s_q;
    dodt_dram_state_type s_d;

    logic [2:0]                  nom_bits;
    logic [1:0]                  wr_bits;
    logic                        term_en;
    logic                        dyn_en;
    logic                        frozen;
    logic [dodt_pkg::LAT_W-1:0]  cwl;
    logic [dodt_pkg::LAT_W-1:0]  cl;
    logic [dodt_pkg::LAT_W-1:0]  al;
    logic [dodt_pkg::LAT_W-1:0]  lat;
    logic [dodt_pkg::LAT_W-1:0]  wr_len;
    logic [dodt_pkg::LAT_W-1:0]  cnt_ext;
    logic                        pin_term;

    always_comb begin
        s_d = s_q;

        if (link.cmd == dodt_pkg::CMD_MRS) begin
            unique case (link.ba)
                dodt_pkg::MR_SEL_0: s_d.mr0 = link.addr;
                dodt_pkg::MR_SEL_1: s_d.mr1 = link.addr;
                dodt_pkg::MR_SEL_2: s_d.mr2 = link.addr;
                default: ;
            endcase
        end

        // (R13) Strength code fields
        nom_bits = {s_q.mr1[dodt_pkg::MR1_NOM_B2],
                    s_q.mr1[dodt_pkg::MR1_NOM_B1],
                    s_q.mr1[dodt_pkg::MR1_NOM_B0]};
        wr_bits = s_q.mr2[dodt_pkg::MR2_WR_HI:dodt_pkg::MR2_WR_LO];
        // (R1) Enable from either strength
        term_en = (nom_bits != 3'h0) || (wr_bits != 2'h0);
        // (R12) Dynamic mode enable
        dyn_en = wr_bits[0] | wr_bits[1];

        // (R7) Latency is WL minus two
        cwl = dodt_pkg::CWL_BASE + {3'h0, s_q.mr2[dodt_pkg::MR2_CWL_LO +: 3]};
        cl = dodt_pkg::CL_BASE + {3'h0, s_q.mr0[dodt_pkg::MR0_CL_LO +: 3]};
        unique case (s_q.mr1[dodt_pkg::MR1_AL_LO +: 2])
            2'h1: al = cl - 6'h01;
            2'h2: al = cl - 6'h02;
            default: al = 6'h00;
        endcase
        lat = cwl + al - dodt_pkg::ODT_LAT_SUB;

        // (R3) Pin history only, no command decode
        s_d.hist = {s_q.hist[dodt_pkg::HIST_W-2:0], link.odt};

        // (R4) Frozen only when DLL dropped in precharge power-down
        frozen = pd_precharge && !s_q.mr0[dodt_pkg::MR0_PD_DLL];
        s_d.sync = dll_locked && !frozen;

        // (R6) Pin seen lat edges ago decides state
        if (frozen) begin
            // (R19) No pin latency when frozen: pin used directly
            pin_term = link.odt;
        end else begin
            pin_term = s_d.hist[lat[4:0]];
        end

        // (R2) Pin gated by mode enables
        s_d.rtt_on = pin_term && term_en;
        // (R11) Off while own drivers hold the lines
        if (dq_drive) begin
            s_d.rtt_on = 1'b0;
        end
        // (R18) Self-refresh ignores the pin
        if (self_refresh) begin
            s_d.rtt_on = 1'b0;
        end

        // Saturating count since the latest write
        if (s_q.wr_cnt != '1) begin
            s_d.wr_cnt = s_q.wr_cnt + 5'h01;
        end
        // (R20) Newest write restarts the window
        if (link.cmd == dodt_pkg::CMD_WRITE) begin
            s_d.wr_cnt = '0;
            s_d.wr_live = dyn_en;
            s_d.wr_bc4 = link.bc4;
        end

        wr_len = s_d.wr_bc4 ? dodt_pkg::ODTH4 : dodt_pkg::ODTH8;
        cnt_ext = {1'b0, s_d.wr_cnt};
        // (R15) Write strength from lat after write
        // (R16) Nominal again at lat plus 4 or 6
        s_d.rtt_wr = s_d.wr_live && dyn_en && (cnt_ext >= lat) && (cnt_ext < lat + wr_len);
        // (R20) Restart keeps write strength, no gap
        if (s_d.wr_live && dyn_en && s_q.rtt_wr && (cnt_ext < lat)) begin
            s_d.rtt_wr = 1'b1;
        end
        if (s_q.wr_live && (cnt_ext >= lat + wr_len)) begin
            s_d.wr_live = 1'b0;
        end
        // (R14) Nominal whenever no write window runs
        if (!s_d.wr_live) begin
            s_d.rtt_wr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rtt_on = s_q.rtt_on;
    assign rtt_wr_sel = s_q.rtt_wr;
    assign rtt_nom_code = {s_q.mr1[dodt_pkg::MR1_NOM_B2],
                           s_q.mr1[dodt_pkg::MR1_NOM_B1],
                           s_q.mr1[dodt_pkg::MR1_NOM_B0]};
    assign rtt_wr_code = s_q.mr2[dodt_pkg::MR2_WR_HI:dodt_pkg::MR2_WR_LO];
    assign sync_mode = s_q.sync;
endmodule : dodt_dram_end
`default_nettype wire

// [logic/dodt_link_if.sv]
// Command and termination pins between controller and DRAM
`timescale 1ns/1ps
`default_nettype none
interface dodt_link_if;
    logic                   odt;
    dodt_pkg::dodt_cmd_type cmd;
    logic                   bc4;
    logic [2:0]             ba;
    logic [dodt_pkg::MR_W-1:0] addr;

    modport ctrl (output odt, output cmd, output bc4, output ba, output addr);
    modport dram (input odt, input cmd, input bc4, input ba, input addr);
endinterface : dodt_link_if
`default_nettype wire

// [logic/dodt_pkg.sv]
// Shared constants and types for the on-die termination link
package dodt_pkg;
    localparam int MR_W = 13;
    localparam int HIST_W = 32;
    localparam int CNT_W = 5;
    localparam int LAT_W = 6;
    // Mode register field positions
    localparam int MR1_NOM_B0 = 2;
    localparam int MR1_NOM_B1 = 6;
    localparam int MR1_NOM_B2 = 9;
    localparam int MR1_AL_LO = 3;
    localparam int MR2_CWL_LO = 3;
    localparam int MR2_WR_LO = 9;
    localparam int MR2_WR_HI = 10;
    localparam int MR0_CL_LO = 4;
    localparam int MR0_PD_DLL = 12;
    localparam logic [2:0] MR_SEL_0 = 3'h0;
    localparam logic [2:0] MR_SEL_1 = 3'h1;
    localparam logic [2:0] MR_SEL_2 = 3'h2;
    // Latency figures in clock cycles
    localparam logic [LAT_W-1:0] CWL_BASE = 6'h05;
    localparam logic [LAT_W-1:0] CL_BASE = 6'h04;
    localparam logic [LAT_W-1:0] ODT_LAT_SUB = 6'h02;
    localparam logic [LAT_W-1:0] ODTH4 = 6'h04;
    localparam logic [LAT_W-1:0] ODTH8 = 6'h06;
    // Controller register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0c;
    localparam int CTRL_ODT_REQ = 0;
    localparam int CTRL_DLL_OFF = 1;
    localparam int CMD_OP_LO = 0;
    localparam int CMD_BC4 = 2;
    localparam int CMD_BA_LO = 4;
    localparam int CMD_ADDR_LO = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ODT = 1;
    localparam int STAT_HOLD = 2;
    localparam int TIME_LEAD_LO = 0;
    localparam int TIME_QUIET_LO = 8;
    localparam logic [4:0] LEAD_RST = 5'h10;
    localparam logic [4:0] QUIET_RST = 5'h18;

    typedef enum logic [1:0] {
        CMD_NOP,
        CMD_WRITE,
        CMD_READ,
        CMD_MRS
    } dodt_cmd_type;
endpackage : dodt_pkg
